//--- hmb_bridge.sv
// Bridge between a 16-bit host bus and a 32-bit multiplexed expansion bus
// ****************************************************************
// Overview of operation
// RULE_01 - Drive stored modifier while owning bus
// RULE_02 - Software loads modifier before master transfers
// RULE_03 - Latch broadcast address, hold for access
// RULE_04 - Increment latched slave address per block
// RULE_05 - Present incremented address on host bus
// RULE_06 - Slave decoder raises host request
// RULE_07 - Two 16-bit registers select slave range
// RULE_08 - A24 adds offset to top nibble
// RULE_09 - A16 I/O accesses not remapped
// RULE_10 - Slave machine runs host cycle, transceivers
// RULE_11 - Host address latched despite early end
// RULE_12 - 8-bit window register gives 64 KB match
// RULE_13 - Broadcast low host bits, high page bits
// RULE_14 - Software programs page before master cycles
// RULE_15 - Master machine sequences expansion cycle
// RULE_16 - Parity generated and checked on 32 bits
// RULE_17 - Write data held until slave accepts
// RULE_18 - Inbound data passes through unlatched
// RULE_19 - Optional byte order swap
// RULE_20 - Interrupts gated by control bits
// RULE_21 - System controller enable, programmable timeout
// RULE_22 - OR into board interrupt, gated
// ****************************************************************
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`default_nettype none
module hmb_bridge #(
  parameter int TMO_W = 16 // Width of timeout counter
) (
  input wire logic mclk_in, // 125 MHz clock
  input wire logic reset_in, // Synchronous, active high
  // Register port
  input wire logic [3:0] reg_addr_in, // Register index
  input wire logic [15:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output var logic [15:0] reg_rdata_out, // Read data, next cycle
  // Host bus as requester (master mode)
  input wire logic [23:0] host_addr_in, // Host address
  input wire logic host_mem_rd_in, // Host memory read, active high
  input wire logic host_mem_wr_in, // Host memory write, active high
  input wire logic [15:0] host_wdata_in, // Host write data
  output var logic host_ready_out, // Host ready, low extends cycle
  output var logic [15:0] host_rdata_out, // Data toward host
  output var logic host_rdata_oe_out, // Drive host data lines
  // Host bus as target (slave mode)
  output var logic [23:0] host_maddr_out, // Address onto host bus
  output var logic host_maddr_oe_out, // Host address drive enable
  output var logic host_mrd_out, // Host read request
  output var logic host_mwr_out, // Host write request
  input wire logic host_mack_in, // Host cycle finished
  input wire logic [15:0] host_mdata_in, // Host read data
  // Expansion bus
  input wire logic [31:0] xb_ad_in, // Multiplexed address/data in
  input wire logic xb_par_in, // Parity in
  output var logic [31:0] xb_ad_out, // Multiplexed address/data out
  output var logic xb_ad_oe_out, // AD drive enable
  output var logic xb_par_out, // Parity out
  output var logic [5:0] xb_am_out, // Address modifier out
  output var logic xb_am_oe_out, // Modifier drive enable
  input wire logic [5:0] xb_am_in, // Address modifier in
  input wire logic xb_as_in, // Address strobe in, active high
  input wire logic xb_ds_in, // Data strobe in
  input wire logic xb_wr_in, // Write, from remote master
  input wire logic xb_blk_in, // Block cycle in progress
  output var logic xb_as_out, // Address strobe out
  output var logic xb_ds_out, // Data strobe out
  output var logic xb_wr_out, // Write out
  input wire logic xb_ack_in, // Remote slave acknowledge
  output var logic xb_ack_out, // Our slave acknowledge
  output var logic xb_breq_out, // Bus request
  input wire logic xb_grant_in, // Grant in daisy chain
  output var logic xb_grant_out, // Grant pass-on
  output var logic xb_busy_out, // Bus owned
  input wire logic xb_irq_in, // Expansion bus interrupt
  output var logic xb_tmo_out, // bus_timeout_unit error
  output var logic board_irq_out // Board interrupt to jumper level
);
  import hmb_pkg::*;
  // All checks below run on the one clock and rest during reset
  default clocking hmb_cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Even parity over a word, shared by generator and checker
  function automatic logic par32(input logic [31:0] w);
    par32 = ^w;
  endfunction
  // Optional byte swap within a halfword
  function automatic logic [15:0] swp(input logic [15:0] w, input logic en);
    swp = en ? {w[7:0], w[15:8]} : w;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [5:0] mam; // Master modifier
    logic [15:0] mpage; // Master page
    logic [7:0] mwin; // Window base
    logic [15:0] sbase; // Slave base
    logic [15:0] smask; // Slave mask
    logic [3:0] sofs; // A24 offset
    logic [HMB_BC_W-1:0] bctl; // Board control
    logic [HMB_ST_W-1:0] stat; // Sticky events
    logic [15:0] tmo; // Timeout period
    logic [15:0] rdata; // Read data
    hmb_mst_e mst; // Master state
    logic [23:0] mlat; // Master address latch
    logic mwr; // Latched direction
    logic [15:0] mdat; // Write data latch
    logic [TMO_W-1:0] tcnt; // Timeout counter
    logic own; // Bus ownership
    hmb_slv_e slv; // Slave state
    logic [31:0] slat; // Slave address latch/counter
    logic [5:0] sam; // Latched modifier
    logic swr; // Slave write
    logic ds_q; // Previous data strobe
    logic ready; // Output copies follow
    logic [15:0] hrd;
    logic hrd_oe;
    logic [23:0] maddr;
    logic maddr_oe;
    logic mrd;
    logic mwro;
    logic [31:0] ad;
    logic ad_oe;
    logic par;
    logic as;
    logic ds;
    logic ack;
    logic breq;
    logic gout;
    logic tmo_o;
    logic irq;
  } hmb_st_s;

  hmb_st_s st_q; // Registered state
  hmb_st_s st_d; // Next state
  logic win_hit; // Master decoder match
  logic host_req; // Slave decoder match
  logic a24; // A24 modifier class
  logic [23:0] smap; // Mapped host address
  logic [15:0] swdata; // Inbound word toward host, optionally swapped

  // ****************************************************************
  // Decoders
  // ****************************************************************
  always_comb begin
    // Window of 64 KB placed by 8-bit base
    win_hit = (host_mem_rd_in | host_mem_wr_in) &&
      (host_addr_in[23:16] == st_q.mwin); // RULE_12
    a24 = (st_q.sam == HMB_AM_A24) || (st_q.sam == HMB_AM_BLK);
    // Range match on upper address bits, masked
    host_req = (a24 || (st_q.sam == HMB_AM_A16)) &&
      (((st_q.slat[31:16] ^ st_q.sbase) & st_q.smask) == 16'h0000); // RULE_06 RULE_07
    // Offset adds to top nibble for A24, I/O passes only its low 10 bits
    if (a24) begin
      smap = {4'(st_q.slat[23:20] + st_q.sofs), st_q.slat[19:0]}; // RULE_08
    end else begin
      smap = {14'h0000, st_q.slat[9:0]}; // RULE_09
    end
    swdata = swp(xb_ad_in[15:0], st_q.bctl[HMB_BC_SWAP]); // RULE_19
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    st_d.rdata = 16'h0000;
    st_d.ack = 1'b0;
    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        HMB_REG_MAMOD: st_d.mam = reg_wdata_in[5:0]; // RULE_02
        HMB_REG_MPAGE: st_d.mpage = reg_wdata_in; // RULE_14
        HMB_REG_MWIN: st_d.mwin = reg_wdata_in[7:0];
        HMB_REG_SBASE: st_d.sbase = reg_wdata_in; // RULE_07
        HMB_REG_SMASK: st_d.smask = reg_wdata_in; // RULE_07
        HMB_REG_SOFS: st_d.sofs = reg_wdata_in[3:0];
        HMB_REG_BCTL: st_d.bctl = reg_wdata_in[HMB_BC_W-1:0];
        HMB_REG_TMO: st_d.tmo = reg_wdata_in; // RULE_21
        default: ;
      endcase
    end
    // Register reads; status read clears events
    if (reg_rd_in) begin
      case (reg_addr_in)
        HMB_REG_MAMOD: st_d.rdata = {10'h000, st_q.mam};
        HMB_REG_MPAGE: st_d.rdata = st_q.mpage;
        HMB_REG_MWIN: st_d.rdata = {8'h00, st_q.mwin};
        HMB_REG_SBASE: st_d.rdata = st_q.sbase;
        HMB_REG_SMASK: st_d.rdata = st_q.smask;
        HMB_REG_SOFS: st_d.rdata = {12'h000, st_q.sofs};
        HMB_REG_BCTL: st_d.rdata = {10'h000, st_q.bctl};
        HMB_REG_STAT: begin
          st_d.rdata = {11'h000, st_q.own, st_q.mst == HMB_M_IDLE, st_q.stat};
          st_d.stat = '0;
        end
        HMB_REG_TMO: st_d.rdata = st_q.tmo;
        default: st_d.rdata = 16'h0000; // Unmapped reads zero
      endcase
    end

    // Master state machine
    case (st_q.mst)
      HMB_M_IDLE: begin
        st_d.ready = 1'b1;
        if (win_hit && st_q.slv == HMB_S_IDLE) begin // RULE_15
          st_d.mlat = host_addr_in; // RULE_11
          st_d.mwr = host_mem_wr_in;
          st_d.mdat = swp(host_wdata_in, st_q.bctl[HMB_BC_SWAP]); // RULE_17 RULE_19
          st_d.ready = 1'b0; // Extend host cycle
          st_d.breq = ~st_q.own;
          st_d.tcnt = '0;
          st_d.mst = HMB_M_ADDR;
        end
      end
      HMB_M_ADDR: begin
        if (st_q.own || xb_grant_in) begin
          st_d.own = 1'b1;
          st_d.breq = 1'b0;
          st_d.ad = {st_q.mpage, st_q.mlat[15:0]}; // RULE_13
          st_d.ad_oe = 1'b1;
          st_d.par = par32({st_q.mpage, st_q.mlat[15:0]}); // RULE_16
          st_d.as = 1'b1;
          st_d.mst = HMB_M_DATA;
        end
      end
      HMB_M_DATA: begin
        st_d.ds = 1'b1;
        st_d.ad = {16'h0000, st_q.mdat}; // RULE_17
        st_d.ad_oe = st_q.mwr;
        st_d.par = par32({16'h0000, st_q.mdat});
        st_d.tcnt = TMO_W'(st_q.tcnt + 1'b1);
        if (!st_q.mwr) begin
          st_d.hrd_oe = 1'b1;
        end
        if (xb_ack_in) begin
          if (!st_q.mwr && (par32(xb_ad_in) != xb_par_in)) begin
            st_d.stat[HMB_ST_PERR] = 1'b1; // RULE_16
          end
          st_d.mst = HMB_M_DONE;
        end else if (st_q.bctl[HMB_BC_SYSC] &&
            st_q.tcnt >= TMO_W'(st_q.tmo)) begin // RULE_21
          st_d.tmo_o = 1'b1;
          st_d.stat[HMB_ST_TMO] = 1'b1;
          st_d.mst = HMB_M_DONE;
        end
      end
      HMB_M_DONE: begin
        st_d.as = 1'b0;
        st_d.ds = 1'b0;
        st_d.ad_oe = 1'b0;
        st_d.hrd_oe = 1'b0;
        st_d.tmo_o = 1'b0;
        st_d.ready = 1'b1;
        // Wait for the host to drop its strobe, else one cycle runs twice
        if (!host_mem_rd_in && !host_mem_wr_in) begin
          st_d.mst = HMB_M_IDLE;
        end
      end
      default: st_d.mst = HMB_M_IDLE;
    endcase
    // Release on request is approximated by release on idle grant
    if (st_q.mst == HMB_M_IDLE && xb_grant_in && st_q.own) begin
      st_d.own = 1'b0;
    end
    st_d.gout = xb_grant_in && !st_q.breq && st_q.mst == HMB_M_IDLE;

    // Slave state machine
    case (st_q.slv)
      HMB_S_IDLE: begin
        if (xb_as_in && st_q.mst == HMB_M_IDLE) begin
          st_d.slat = xb_ad_in; // RULE_03
          st_d.sam = xb_am_in;
          st_d.swr = xb_wr_in;
          st_d.slv = HMB_S_DEC;
        end
      end
      HMB_S_DEC: begin
        if (!xb_as_in) begin
          st_d.slv = HMB_S_IDLE;
        end else if (host_req && xb_ds_in) begin // RULE_10
          st_d.maddr = smap; // RULE_03 RULE_05
          st_d.maddr_oe = 1'b1;
          st_d.mrd = ~st_q.swr;
          st_d.mwro = st_q.swr;
          st_d.slv = HMB_S_HOST;
        end
      end
      HMB_S_HOST: begin
        if (host_mack_in) begin
          st_d.mrd = 1'b0;
          st_d.mwro = 1'b0;
          st_d.ack = 1'b1;
          st_d.stat[HMB_ST_SDONE] = 1'b1;
          st_d.ad_oe = ~st_q.swr; // RULE_10
          st_d.slv = HMB_S_ACK;
        end
      end
      HMB_S_ACK: begin
        if (!xb_as_in) begin
          st_d.maddr_oe = 1'b0;
          st_d.ad_oe = 1'b0;
          st_d.slv = HMB_S_IDLE;
        end else if (xb_blk_in && xb_ds_in && !st_q.ds_q) begin
          st_d.slat = st_q.slat + 32'h0000_0002; // RULE_04
          st_d.ad_oe = 1'b0;
          st_d.slv = HMB_S_DEC;
        end
      end
      default: st_d.slv = HMB_S_IDLE;
    endcase
    st_d.ds_q = xb_ds_in;

    // Board interrupt: enabled events ORed, then gated
    st_d.irq = st_q.bctl[HMB_BC_BDIE] && // RULE_22
      ((st_q.bctl[HMB_BC_IE_SLV] && st_q.stat[HMB_ST_SDONE]) ||
       (st_q.bctl[HMB_BC_IE_EXC] && (st_q.stat[HMB_ST_PERR] | st_q.stat[HMB_ST_TMO])) ||
       (st_q.bctl[HMB_BC_IE_EXT] && xb_irq_in)); // RULE_20
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_q <= '0;
      st_q.tmo <= HMB_TMO_RST;
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs, from flip-flops except host_rdata_out, xb_ad_out and xb_par_out
  // ****************************************************************
  assign reg_rdata_out = st_q.rdata;
  assign host_ready_out = st_q.ready;
  assign host_rdata_out = swdata; // RULE_18
  assign host_rdata_oe_out = st_q.hrd_oe;
  assign host_maddr_out = st_q.maddr;
  assign host_maddr_oe_out = st_q.maddr_oe;
  assign host_mrd_out = st_q.mrd;
  assign host_mwr_out = st_q.mwro;
  assign xb_ad_out = st_q.slv == HMB_S_ACK && !st_q.swr ?
    {16'h0000, host_mdata_in} : st_q.ad;
  assign xb_ad_oe_out = st_q.ad_oe;
  assign xb_par_out = st_q.slv == HMB_S_ACK && !st_q.swr ?
    par32({16'h0000, host_mdata_in}) : st_q.par; // RULE_16
  assign xb_am_out = st_q.mam; // RULE_01
  assign xb_am_oe_out = st_q.own; // RULE_01
  assign xb_as_out = st_q.as;
  assign xb_ds_out = st_q.ds;
  assign xb_wr_out = st_q.mwr;
  assign xb_ack_out = st_q.ack;
  assign xb_breq_out = st_q.breq;
  assign xb_grant_out = st_q.gout;
  assign xb_busy_out = st_q.own;
  assign xb_tmo_out = st_q.tmo_o;
  assign board_irq_out = st_q.irq;

  // ****************************************************************
  // Checks and covers
  // ****************************************************************
  AST_AM_DRIVE: assert property (xb_as_out |-> xb_am_oe_out && xb_busy_out) // RULE_01
    else $error("Strobe without bus ownership");
  AST_SLV_HOLD: assert property ( // RULE_03
    st_q.slv == HMB_S_HOST && !host_mack_in |=> $stable(host_maddr_out))
    else $error("Host address moved");
  AST_BLK_INC: assert property ( // RULE_04
    st_q.slv == HMB_S_ACK && xb_as_in && xb_blk_in && xb_ds_in && !st_q.ds_q
    |=> st_q.slat == $past(st_q.slat) + 32'h0000_0002) else $error("Block address stuck");
  AST_BCAST: assert property ( // RULE_13
    $rose(xb_as_out) |-> xb_ad_out == {st_q.mpage, st_q.mlat[15:0]})
    else $error("Broadcast address wrong");
  AST_PAR_OUT: assert property ( // RULE_16
    xb_ad_oe_out |-> xb_par_out == ^xb_ad_out)
    else $error("Outgoing parity wrong");
  AST_WDATA_HOLD: assert property ( // RULE_17
    xb_ds_out && xb_wr_out |-> xb_ad_out[15:0] == st_q.mdat)
    else $error("Write data not held");
  AST_IRQ_GATE: assert property ( // RULE_22
    !st_q.bctl[HMB_BC_BDIE] |=> !board_irq_out)
    else $error("Board interrupt not gated");
  // Main scenarios: timeout, block beat, master read
  CV_MST_TMO: cover property (xb_tmo_out);
  CV_SLV_BLK: cover property (st_q.slv == HMB_S_ACK ##1 st_q.slv == HMB_S_DEC);
  CV_MST_RD: cover property (xb_ds_out && !xb_wr_out && xb_ack_in);
endmodule // hmb_bridge
`default_nettype wire

//--- hmb_pkg.sv
// Package of constants and types for the host to multiplexed bus bridge
`default_nettype none
package hmb_pkg;
  // ****************************************************************
  // Register offsets (word index on the plain register port)
  // ****************************************************************
  localparam logic [3:0] HMB_REG_MAMOD = 4'h0; // Master address modifier
  localparam logic [3:0] HMB_REG_MPAGE = 4'h1; // Master page, upper 16 bits
  localparam logic [3:0] HMB_REG_MWIN = 4'h2; // Master window base, 8 bits
  localparam logic [3:0] HMB_REG_SBASE = 4'h3; // Slave range base, 16 bits
  localparam logic [3:0] HMB_REG_SMASK = 4'h4; // Slave range mask, 16 bits
  localparam logic [3:0] HMB_REG_SOFS = 4'h5; // Slave A24 offset, 4 bits
  localparam logic [3:0] HMB_REG_BCTL = 4'h6; // board_control_register
  localparam logic [3:0] HMB_REG_STAT = 4'h7; // Status, read clears events
  localparam logic [3:0] HMB_REG_TMO = 4'h8; // Bus timeout period
  // ****************************************************************
  // Board control field positions
  // ****************************************************************
  localparam int HMB_BC_IE_SLV = 0; // Enable slave-done interrupt
  localparam int HMB_BC_IE_EXC = 1; // Enable master exception interrupt
  localparam int HMB_BC_IE_EXT = 2; // Enable expansion bus interrupt
  localparam int HMB_BC_SWAP = 3; // Byte swap option
  localparam int HMB_BC_SYSC = 4; // System controller enable
  localparam int HMB_BC_BDIE = 5; // board_interrupt_enable
  localparam int HMB_BC_W = 6; // Width of control register
  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int HMB_ST_PERR = 0; // Incoming parity error
  localparam int HMB_ST_TMO = 1; // Master bus timeout
  localparam int HMB_ST_SDONE = 2; // Slave cycle completed
  localparam int HMB_ST_W = 3; // Status width
  // ****************************************************************
  // Reset values and modifier codes
  // ****************************************************************
  localparam logic [5:0] HMB_AM_A16 = 6'h29; // Short I/O modifier
  localparam logic [5:0] HMB_AM_A24 = 6'h39; // Standard data modifier
  localparam logic [5:0] HMB_AM_BLK = 6'h3b; // Standard block modifier
  localparam logic [15:0] HMB_TMO_RST = 16'h00ff; // Timeout reset value
  // ****************************************************************
  // State machine encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    HMB_M_IDLE = 2'b00, // Wait for host request
    HMB_M_ADDR = 2'b01, // Address broadcast
    HMB_M_DATA = 2'b10, // Data phase, wait ack
    HMB_M_DONE = 2'b11 // Release host
  } hmb_mst_e;
  typedef enum logic [1:0] {
    HMB_S_IDLE = 2'b00, // Wait for address strobe
    HMB_S_DEC = 2'b01, // Decode latched address
    HMB_S_HOST = 2'b10, // Host cycle running
    HMB_S_ACK = 2'b11 // Acknowledge on expansion bus
  } hmb_slv_e;
endpackage : hmb_pkg
`default_nettype wire

//--- hmb_xb_partner.sv
// Far-side model: arbiter, remote slave and remote master address driver
`default_nettype none
module hmb_xb_partner (
  input wire logic clk_in, // Bench clock
  input wire logic reset_in, // Synchronous, active high
  input wire logic breq_in, // Bridge bus request
  input wire logic ds_in, // Bridge data strobe
  input wire logic wr_in, // Bridge write
  input wire logic slow_in, // Answer late when high
  input wire logic mute_in, // Never answer, forces a timeout
  input wire logic m_en_in, // Remote master drives an address
  input wire logic [31:0] m_ad_in, // Remote master address
  input wire logic [31:0] rdata_in, // Remote slave read data
  output logic grant_out, // Grant into the daisy chain
  output logic ack_out, // Remote slave acknowledge
  output logic [31:0] ad_out, // Lines seen by the bridge
  output logic par_out // Parity of those lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q; // Cycles spent in the data phase
  logic [31:0] last_q; // Last value on the lines
  // ****************************************************************
  // Arbiter and slave answer
  // ****************************************************************
  // Grant follows request one cycle later, like a lazy arbiter
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      grant_out <= 1'b0;
      ack_out <= 1'b0;
      wait_q <= 3'h0;
      last_q <= 32'h0;
    end else begin
      grant_out <= breq_in;
      last_q <= ad_out;
      if (!ds_in) begin
        wait_q <= 3'h0;
        ack_out <= 1'b0;
      end else if (!mute_in) begin
        wait_q <= wait_q + 3'h1;
        ack_out <= (wait_q >= (slow_in ? 3'h3 : 3'h0));
      end
    end
  end
  // Released lines toggle so a stale value can never look valid
  always_comb begin
    if (m_en_in) begin
      ad_out = m_ad_in;
    end else if (ack_out && !wr_in) begin
      ad_out = rdata_in;
    end else begin
      ad_out = ~last_q;
    end
  end
  assign par_out = ^ad_out; // Keep incoming parity clean
endmodule // hmb_xb_partner
`default_nettype wire

//--- test_hmb_bridge.sv
// Self-checking testbench of the host to multiplexed bus bridge
`default_nettype none
module test_hmb_bridge;
  timeunit 1ns;
  timeprecision 1ps;
  import hmb_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, hrd = 0, hwr = 0, mack = 0;
  logic [3:0] ra = 4'h0;
  logic [15:0] wd = 16'h0, hwd = 16'h0, mdata = 16'h0, rdat, hrdata, tmp;
  logic [23:0] ha = 24'h0, maddr, maddr_exp_a;
  logic [31:0] xad_in, xad, rdata = 32'h0, m_ad = 32'h0, cap_a, cap_d;
  logic [5:0] am, am_in = 6'h0, cap_am;
  logic xpi, xpar, aoe, amoe, xas, xds, xwr, ack, xack, breq, grant, busy, irq, rdy, cap_p;
  logic slow = 0, mute = 0, m_en = 0, as_in = 0, ds_in = 0, wr_in = 0, blk = 0, irq_in = 0;
  logic as_d, ds_d, moe, mrd;
  int mismatches = 0, checked = 0, cycles = 0;
  // ****************************************************************
  // Clock, design and far side
  // ****************************************************************
  initial begin
    forever #4 clk = ~clk;
  end
  hmb_bridge i_dut (.mclk_in(clk), .reset_in(rst), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .host_addr_in(ha),
    .host_mem_rd_in(hrd), .host_mem_wr_in(hwr), .host_wdata_in(hwd), .host_ready_out(rdy),
    .host_rdata_out(hrdata), .host_rdata_oe_out(), .host_maddr_out(maddr),
    .host_maddr_oe_out(moe), .host_mrd_out(mrd), .host_mwr_out(), .host_mack_in(mack),
    .host_mdata_in(mdata), .xb_ad_in(xad_in), .xb_par_in(xpi), .xb_ad_out(xad),
    .xb_ad_oe_out(aoe), .xb_par_out(xpar), .xb_am_out(am), .xb_am_oe_out(amoe),
    .xb_am_in(am_in), .xb_as_in(as_in), .xb_ds_in(ds_in), .xb_wr_in(wr_in), .xb_blk_in(blk),
    .xb_as_out(xas), .xb_ds_out(xds), .xb_wr_out(xwr), .xb_ack_in(ack), .xb_ack_out(xack),
    .xb_breq_out(breq), .xb_grant_in(grant), .xb_grant_out(), .xb_busy_out(busy),
    .xb_irq_in(irq_in), .xb_tmo_out(), .board_irq_out(irq));
  hmb_xb_partner i_far (.clk_in(clk), .reset_in(rst), .breq_in(breq), .ds_in(xds),
    .wr_in(xwr), .slow_in(slow), .mute_in(mute), .m_en_in(m_en), .m_ad_in(m_ad),
    .rdata_in(rdata), .grant_out(grant), .ack_out(ack), .ad_out(xad_in), .par_out(xpi));
  // ****************************************************************
  // Monitor of the bridge's own broadcasts
  // ****************************************************************
  // Capture address at strobe rise, data and read return at acknowledge
  always @(posedge clk) begin
    cycles <= cycles + 1;
    as_d <= xas;
    ds_d <= xds;
    if (xas && !as_d) begin
      cap_a <= xad;
      cap_am <= am;
      cap_p <= (xpar === ^xad) && amoe && busy;
    end
    if (xds && ack) begin
      cap_d <= xwr ? xad : {16'h0, hrdata};
    end
  end
  // Hang guard, well above the longest sequence
  always @(posedge clk) begin
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    ra <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    ra <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  // Host memory cycle, held until the bridge lets the host go
  task automatic host_cyc(input logic [23:0] a, input logic w, input logic [15:0] d);
    int n;
    @(posedge clk);
    ha <= a; hwr <= w; hrd <= !w; hwd <= d;
    for (n = 0; n < 8 && rdy !== 1'b0; n++) @(posedge clk);
    for (n = 0; n < 300 && rdy !== 1'b1; n++) @(posedge clk);
    hwr <= 1'b0; hrd <= 1'b0;
    @(posedge clk);
  endtask
  // Remote master cycle into host space, one beat per data strobe; returns last host address
  task automatic slv_cyc(input logic [5:0] m, input logic [31:0] a, input int beats,
      output logic [23:0] h);
    int n;
    @(posedge clk);
    am_in <= m; m_ad <= a; m_en <= 1'b1; as_in <= 1'b1; blk <= (beats > 1);
    @(posedge clk);
    m_en <= 1'b0;
    repeat (beats) begin
      ds_in <= 1'b1;
      for (n = 0; n < 32 && mrd !== 1'b1; n++) @(posedge clk);
      h = moe ? maddr : 24'hx;
      mack <= 1'b1; mdata <= 16'h3c3c;
      for (n = 0; n < 32 && xack !== 1'b1; n++) @(posedge clk);
      check(xack, 1'b1);
      check(xad[15:0], 16'h3c3c);
      check({aoe, xpar}, {1'b1, ^xad});
      mack <= 1'b0; ds_in <= 1'b0;
      @(posedge clk);
    end
    as_in <= 1'b0; blk <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reg_rd(HMB_REG_TMO, tmp);
    check(tmp, HMB_TMO_RST);
    reg_rd(4'hf, tmp);
    check(tmp, 16'h0);
    reg_wr(4'hf, 16'hffff);
    // Software programs modifier, page and window before cycles
    reg_wr(HMB_REG_MAMOD, {10'h0, HMB_AM_A24});
    reg_wr(HMB_REG_MPAGE, 16'h1234);
    reg_wr(HMB_REG_MWIN, 16'h000d);
    reg_rd(HMB_REG_MWIN, tmp);
    check(tmp, 16'h000d);
    // Master write, slow slave
    slow <= 1'b1;
    host_cyc(24'h0d5678, 1'b1, 16'hbeef);
    check(cap_a, 32'h12345678);
    check(cap_am, HMB_AM_A24);
    check(cap_p, 1'b1);
    check(cap_d[15:0], 16'hbeef);
    check(rdy, 1'b1);
    // Master reads, plain then swapped
    slow <= 1'b0;
    rdata <= 32'h0000a55a;
    host_cyc(24'h0dfffe, 1'b0, 16'h0);
    check(cap_d[15:0], 16'ha55a);
    reg_wr(HMB_REG_BCTL, 16'h1 << HMB_BC_SWAP);
    host_cyc(24'h0d0000, 1'b0, 16'h0);
    check(cap_d[15:0], 16'h5aa5);
    check(cap_a, 32'h12340000);
    // Outside the window the host is never held
    host_cyc(24'h0e0000, 1'b0, 16'h0);
    check(breq, 1'b0);
    check(rdy, 1'b1);
    // Slave cycles: open range, offset on A24 only
    reg_wr(HMB_REG_SBASE, 16'h0000);
    reg_wr(HMB_REG_SMASK, 16'h0000);
    reg_wr(HMB_REG_SOFS, 16'h0003);
    slv_cyc(HMB_AM_A24, 32'h00512346, 1, maddr_exp_a);
    check(maddr_exp_a, 24'h812346);
    slv_cyc(HMB_AM_A16, 32'h000003f0, 1, maddr_exp_a);
    check(maddr_exp_a, 24'h0003f0);
    // Block of two beats: second host address is one word on
    slv_cyc(HMB_AM_BLK, 32'h00512346, 2, maddr_exp_a);
    check(maddr_exp_a, 24'h812348);
    reg_rd(HMB_REG_STAT, tmp);
    check(tmp[HMB_ST_SDONE], 1'b1);
    // Interrupt gated by the board enable
    irq_in <= 1'b1;
    reg_wr(HMB_REG_BCTL, (16'h1 << HMB_BC_IE_EXT) | (16'h1 << HMB_BC_BDIE));
    repeat (3) @(posedge clk);
    check(irq, 1'b1);
    reg_wr(HMB_REG_BCTL, 16'h1 << HMB_BC_IE_EXT);
    repeat (3) @(posedge clk);
    check(irq, 1'b0);
    irq_in <= 1'b0;
    // Timeout with a silent slave
    reg_wr(HMB_REG_TMO, 16'h0010);
    reg_wr(HMB_REG_BCTL, 16'h1 << HMB_BC_SYSC);
    mute <= 1'b1;
    host_cyc(24'h0d0010, 1'b0, 16'h0);
    check(rdy, 1'b1);
    reg_rd(HMB_REG_STAT, tmp);
    check(tmp[HMB_ST_TMO], 1'b1);
    reg_rd(HMB_REG_STAT, tmp);
    check(tmp[HMB_ST_TMO], 1'b0);
    mute <= 1'b0;
    print_verdict();
  end
endmodule // test_hmb_bridge
`default_nettype wire
